// ==== pss_buf2.sv ====
`timescale 1ns/1ps
module pss_buf2 (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   // Fill side
   pss_rec_if.snk           in_if,
   // Drain side
   output logic             out_valid_o,
   input  wire logic        out_ready_i,
   output pss_pkg::pss_rec_s out_rec_o
);
   logic              skid_v_r;
   pss_pkg::pss_rec_s skid_r;
   logic              push;
   logic              pop;
   // Ready only while the spare slot is free
   assign in_if.ready = !skid_v_r;
   assign push        = in_if.valid && !skid_v_r;
   assign pop         = out_valid_o && out_ready_i;
   // Head entry, presented from its register
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         out_valid_o <= 1'b0;
         out_rec_o   <= '0;
      end
      else if (!out_valid_o || pop)
      begin
         out_valid_o <= skid_v_r || push;
         out_rec_o   <= skid_v_r ? skid_r : in_if.data;
      end
   end
   // Spare entry, filled when the head stalls
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         skid_v_r <= 1'b0;
         skid_r   <= '0;
      end
      else if (skid_v_r && pop)
         skid_v_r <= 1'b0;
      else if (push && out_valid_o && !pop)
      begin
         skid_v_r <= 1'b1;
         skid_r   <= in_if.data;
      end
   end
endmodule

// ==== pss_defines.svh ====
// Function
// (RL1) Every submessage opens with a kind octet, a flags octet and a 16-bit length.
// (RL2) Kind codes 0x00 to 0x7F are classed as protocol-defined kinds.
// (RL3) Protocol kinds decode to the fifteen fixed codes from PAD to HEARTBEAT_FRAG.
// (RL4) Kind codes 0x80 to 0xFF are vendor kinds read under the current vendor id.
// (RL5) Flags bit 0 picks the byte order: zero big-endian, one little-endian.
// (RL6) Flag bits unused by a kind are sent as zero and ignored on receipt.
// (RL7) A nonzero length spans contents to the next header, or the message rest.
// (RL8) A zero length on a kind other than PAD or INFO_TS makes it the last one.
// (RL9) A zero length on PAD or INFO_TS puts the next header right after this one.
// (RL10) On AckNack flag bit 1 set means no reply, clear means a reply is owed.
// (RL11) On NoKeyData flag bits 1 and 2 are inline-QoS and data-present.
// (RL12) NoKeyData carries the inline QoS list only while its inline-QoS flag is set.
// (RL13) NoKeyData carries the serialized data only while its data flag is set.
// (RL14) The compact IPv4 locator is a 32-bit address then a 32-bit port.
// (RL15) Each primitive field sits at an offset that is a multiple of its size.
// (RL16) A length pointing past the message end flags it malformed and stops the walk.
// (RL17) The length field is read in the byte order of its own header's flags.
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH
// Submessage kind codes
`define PSS_K_PAD        8'h01
`define PSS_K_DATA       8'h02
`define PSS_K_NOKEY      8'h03
`define PSS_K_ACKNACK    8'h06
`define PSS_K_HEARTBEAT  8'h07
`define PSS_K_GAP        8'h08
`define PSS_K_INFO_TS    8'h09
`define PSS_K_INFO_SRC   8'h0C
`define PSS_K_REPLY_IP4  8'h0D
`define PSS_K_INFO_DST   8'h0E
`define PSS_K_INFO_REPLY 8'h0F
`define PSS_K_DATA_FRAG  8'h10
`define PSS_K_NOKEY_FRAG 8'h11
`define PSS_K_NACK_FRAG  8'h12
`define PSS_K_HB_FRAG    8'h13
`define PSS_K_PROTO_MAX  8'h7F
// Flag bit positions
`define PSS_FLG_E 0
`define PSS_FLG_F 1
`define PSS_FLG_Q 1
`define PSS_FLG_D 2
// Used-flag masks per kind
`define PSS_M_DATA  8'h1F
`define PSS_M_EQD   8'h07
`define PSS_M_EQ    8'h03
`define PSS_M_E     8'h01
`define PSS_M_ALL   8'hFF
// Sizes and reset values
`define PSS_HDR_LAST 2'h3
`define PSS_LOC_OCT  4'h8
`define PSS_RST_RDY  1'b1
`endif

// ==== pss_kind_decode.sv ====
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_kind_decode (
   // Header octets
   input  wire logic [7:0] kind_i,
   input  wire logic [7:0] flags_i,
   // Classification
   output logic            proto_o,
   output logic            vendor_o,
   output logic            known_o,
   output logic [7:0]      flags_o
);
   logic [7:0] mask;
   // Kind range split
   assign proto_o  = kind_i <= `PSS_K_PROTO_MAX; // RL2
   assign vendor_o = !proto_o;                   // RL4
   // Known codes and the flag bits they use
   always_comb
   begin
      known_o = 1'b1;
      mask    = `PSS_M_ALL;
      case (kind_i) // RL3
         `PSS_K_DATA:       mask = `PSS_M_DATA;
         `PSS_K_NOKEY:      mask = `PSS_M_EQD;
         `PSS_K_DATA_FRAG:  mask = `PSS_M_EQD;
         `PSS_K_ACKNACK:    mask = `PSS_M_EQ;
         `PSS_K_NOKEY_FRAG: mask = `PSS_M_EQ;
         `PSS_K_GAP:        mask = `PSS_M_E;
         `PSS_K_PAD, `PSS_K_HEARTBEAT, `PSS_K_INFO_TS, `PSS_K_INFO_SRC,
         `PSS_K_REPLY_IP4, `PSS_K_INFO_DST, `PSS_K_INFO_REPLY,
         `PSS_K_NACK_FRAG, `PSS_K_HB_FRAG: mask = `PSS_M_ALL;
         default:           known_o = 1'b0;
      endcase
   end
   // Unused bits ignored
   assign flags_o = flags_i & mask; // RL6
endmodule

// ==== pss_parser.sv ====
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_parser #(
   parameter int LEN_W = 32
) (
   // Clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             reset_i,
   // Submessage byte stream in
   input  wire logic             msg_start_i,
   input  wire logic [LEN_W-1:0] msg_len_i,
   input  wire logic [15:0]      vendor_id_i,
   input  wire logic             byte_valid_i,
   input  wire logic [7:0]       byte_i,
   output logic                  byte_ready_o,
   // Decoded submessages out
   output logic                  sub_valid_o,
   input  wire logic             sub_ready_i,
   output pss_pkg::pss_rec_s     sub_rec_o,
   // Per-message status
   output logic                  malformed_o,
   output logic                  align_err_o,
   output logic                  msg_done_o
);

   // Lengths below 17 bits cannot hold a message past 64k
   if (LEN_W < 17)
   begin : g_len_chk
      $error("pss_parser: LEN_W must be at least 17");
   end

   // CDR unsigned short in the chosen byte order
   function automatic logic [15:0] cdr16(input logic le,
                                         input logic [7:0] b0,
                                         input logic [7:0] b1);
      cdr16 = le ? {b1, b0} : {b0, b1};
   endfunction

   // CDR unsigned long in the chosen byte order
   function automatic logic [31:0] cdr32(input logic le,
                                         input logic [7:0] b0,
                                         input logic [7:0] b1,
                                         input logic [7:0] b2,
                                         input logic [7:0] b3);
      cdr32 = le ? {b3, b2, b1, b0} : {b0, b1, b2, b3};
   endfunction

   pss_pkg::pss_state_e state_r;
   pss_pkg::pss_state_e state_nxt;

   logic             take;
   logic             hdr_last;
   logic [LEN_W-1:0] msg_len_r;
   logic [LEN_W-1:0] pos_r;
   logic [LEN_W-1:0] body_r;
   logic [1:0]       hidx_r;
   logic [7:0]       hb_r [0:2];
   logic [3:0]       bidx_r;
   logic [7:0]       loc_r [0:7];
   logic [7:0]       kind_r;
   logic [7:0]       flags_r;
   logic [15:0]      octets_r;
   logic             final_r;
   logic [15:0]      vid_r;

   // Header evaluation on its fourth octet
   logic [15:0]      h_len;
   logic [LEN_W-1:0] h_len_w;
   logic [LEN_W-1:0] h_pos;
   logic [LEN_W-1:0] h_rem;
   logic [LEN_W-1:0] h_body;
   logic [LEN_W-1:0] h_next;
   logic             h_over;
   logic             h_zero_ok;
   logic             h_bad;
   logic             h_final;
   logic             h_misalign;

   // Decoder results for the stored header
   logic             d_proto;
   logic             d_vendor;
   logic             d_known;
   logic [7:0]       d_flags;
   logic             le;

   pss_rec_if rec_if ();

   // Byte handshake
   assign take     = byte_valid_i && byte_ready_o;
   assign hdr_last = (state_r == pss_pkg::S_HDR)
                     && (hidx_r == `PSS_HDR_LAST) && take; // RL1

   // Length in the header's own byte order
   assign h_len     = cdr16(hb_r[1][`PSS_FLG_E], hb_r[2], byte_i); // RL17
   assign h_len_w   = LEN_W'(h_len);
   assign h_pos     = pos_r + LEN_W'(1);
   assign h_over    = h_pos > msg_len_r;
   assign h_rem     = msg_len_r - h_pos;
   assign h_zero_ok = (hb_r[0] == `PSS_K_PAD)
                      || (hb_r[0] == `PSS_K_INFO_TS);
   assign h_next    = h_pos + h_body;

   // Where the next header starts, and whether this is the last one
   always_comb
   begin
      h_bad   = 1'b0;
      h_final = 1'b0;
      h_body  = '0;
      if (h_over)
         h_bad = 1'b1; // RL16
      else if (h_len != 16'h0000)
      begin
         if (h_len_w > h_rem)
            h_bad = 1'b1; // RL16
         else
         begin
            h_body  = h_len_w;           // RL7
            h_final = (h_len_w == h_rem); // RL7
         end
      end
      else if (!h_zero_ok)
      begin
         h_body  = h_rem; // RL8
         h_final = 1'b1;  // RL8
      end
      else
         h_final = (h_rem == '0); // RL9
   end

   // Next header must land on a word boundary
   assign h_misalign = !h_bad && !h_final
                       && (h_next[1:0] != 2'h0); // RL15

   // Walk sequencing
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         pss_pkg::S_IDLE:
            if (take && msg_start_i)
               state_nxt = pss_pkg::S_HDR;
         pss_pkg::S_HDR:
            if (hdr_last)
            begin
               if (h_bad)
                  state_nxt = (h_over || h_rem == '0) ? pss_pkg::S_IDLE
                                                      : pss_pkg::S_DRAIN;
               else if (h_body != '0)
                  state_nxt = pss_pkg::S_BODY;
               else
                  state_nxt = pss_pkg::S_EMIT; // RL9
            end
         pss_pkg::S_BODY:
            if (take && body_r == LEN_W'(1))
               state_nxt = pss_pkg::S_EMIT;
         pss_pkg::S_EMIT:
            if (rec_if.ready)
               state_nxt = final_r ? pss_pkg::S_IDLE : pss_pkg::S_HDR;
         pss_pkg::S_DRAIN:
            if (take && h_pos >= msg_len_r)
               state_nxt = pss_pkg::S_IDLE; // RL16
         default:
            state_nxt = pss_pkg::S_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
         state_r <= pss_pkg::S_IDLE;
      else
         state_r <= state_nxt;
   end

   // Stall the stream while a record waits for the buffer
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
         byte_ready_o <= `PSS_RST_RDY;
      else
         byte_ready_o <= (state_nxt != pss_pkg::S_EMIT);
   end

   // Message length, vendor id and octet position
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         msg_len_r <= '0;
         pos_r     <= '0;
         vid_r     <= 16'h0000;
      end
      else if (state_r == pss_pkg::S_IDLE)
      begin
         if (take && msg_start_i)
         begin
            msg_len_r <= msg_len_i;
            pos_r     <= LEN_W'(1);
            vid_r     <= vendor_id_i; // RL4
         end
      end
      else if (take)
         pos_r <= h_pos;
   end

   // Header octet collection
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         hidx_r <= 2'h0;
         hb_r   <= '{default: 8'h00};
      end
      else if (take && (state_r == pss_pkg::S_IDLE) && msg_start_i)
      begin
         hb_r[0] <= byte_i;
         hidx_r  <= 2'h1;
      end
      else if (take && (state_r == pss_pkg::S_HDR))
      begin
         if (hidx_r != `PSS_HDR_LAST)
            hb_r[hidx_r] <= byte_i; // RL1
         hidx_r <= hidx_r + 2'h1;
      end
   end

   // Latched header fields for the record
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         kind_r   <= 8'h00;
         flags_r  <= 8'h00;
         octets_r <= 16'h0000;
         final_r  <= 1'b0;
      end
      else if (hdr_last)
      begin
         kind_r   <= hb_r[0];
         flags_r  <= hb_r[1];
         octets_r <= h_len;
         final_r  <= h_final;
      end
   end

   // Contents countdown and locator capture
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         body_r <= '0;
         bidx_r <= 4'h0;
         loc_r  <= '{default: 8'h00};
      end
      else if (hdr_last)
      begin
         body_r <= h_body;
         bidx_r <= 4'h0;
      end
      else if (take && (state_r == pss_pkg::S_BODY))
      begin
         body_r <= body_r - LEN_W'(1);
         if (bidx_r != `PSS_LOC_OCT)
         begin
            loc_r[bidx_r[2:0]] <= byte_i; // RL14
            bidx_r             <= bidx_r + 4'h1;
         end
      end
   end

   // Malformed flag, cleared when the next message starts
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
         malformed_o <= 1'b0;
      else if (hdr_last && h_bad)
         malformed_o <= 1'b1; // RL16
      else if (take && (state_r == pss_pkg::S_IDLE) && msg_start_i)
         malformed_o <= 1'b0;
   end

   // Misaligned next header flag, same lifetime
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
         align_err_o <= 1'b0;
      else if (hdr_last && h_misalign)
         align_err_o <= 1'b1; // RL15
      else if (take && (state_r == pss_pkg::S_IDLE) && msg_start_i)
         align_err_o <= 1'b0;
   end

   // One-cycle pulse as the walk of a message ends
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
         msg_done_o <= 1'b0;
      else
         msg_done_o <= (state_r != pss_pkg::S_IDLE)
                       && (state_nxt == pss_pkg::S_IDLE);
   end

   // Kind classification and unused flag masking
   pss_kind_decode u_dec (
      .kind_i   (kind_r),
      .flags_i  (flags_r),
      .proto_o  (d_proto),
      .vendor_o (d_vendor),
      .known_o  (d_known),
      .flags_o  (d_flags)
   );

   assign le = flags_r[`PSS_FLG_E]; // RL5

   // Record offered to the buffer
   assign rec_if.valid = (state_r == pss_pkg::S_EMIT);

   // Record contents
   always_comb
   begin
      rec_if.data              = '0;
      rec_if.data.vendor_id    = vid_r;
      rec_if.data.kind         = kind_r;
      rec_if.data.flags        = d_flags;  // RL6
      rec_if.data.octets       = octets_r;
      rec_if.data.little_e     = le;       // RL5
      rec_if.data.proto_kind   = d_proto;  // RL2
      rec_if.data.vendor_kind  = d_vendor; // RL4
      rec_if.data.known_kind   = d_known;  // RL3
      rec_if.data.final_sub    = final_r;
      rec_if.data.reply_req    = (kind_r == `PSS_K_ACKNACK)
                                 && !flags_r[`PSS_FLG_F]; // RL10
      rec_if.data.inline_qos   = (kind_r == `PSS_K_NOKEY)
                                 && flags_r[`PSS_FLG_Q]; // RL11 RL12
      rec_if.data.data_present = (kind_r == `PSS_K_NOKEY)
                                 && flags_r[`PSS_FLG_D]; // RL11 RL13
      rec_if.data.loc_valid    = (kind_r == `PSS_K_REPLY_IP4)
                                 && (bidx_r == `PSS_LOC_OCT); // RL14
      rec_if.data.loc_addr     = cdr32(le, loc_r[0], loc_r[1],
                                       loc_r[2], loc_r[3]); // RL14
      rec_if.data.loc_port     = cdr32(le, loc_r[4], loc_r[5],
                                       loc_r[6], loc_r[7]); // RL14
   end

   // Two-entry buffer toward the consumer
   pss_buf2 u_buf (
      .clk_sys_i   (clk_sys_i),
      .reset_i     (reset_i),
      .in_if       (rec_if.snk),
      .out_valid_o (sub_valid_o),
      .out_ready_i (sub_ready_i),
      .out_rec_o   (sub_rec_o)
   );

endmodule

// ==== pss_parser_sva.sv ====
`timescale 1ns/1ps
module pss_parser_sva #(
   parameter int LEN_W = 32
) (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   // Record side
   input  wire logic        sub_valid_o,
   input  wire logic        sub_ready_i,
   input  pss_pkg::pss_rec_s sub_rec_o,
   input  wire logic        msg_done_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);
   // A stalled record stays put until taken
   hold_rec_a: assert property (sub_valid_o && !sub_ready_i |=>
      sub_valid_o && $stable(sub_rec_o)) else $error("record lost");
   proto_class_a: assert property (sub_valid_o |->
      sub_rec_o.proto_kind == (sub_rec_o.kind <= 8'h7F))
      else $error("protocol class wrong");
   vendor_class_a: assert property (sub_valid_o |->
      sub_rec_o.vendor_kind == sub_rec_o.kind[7])
      else $error("vendor class wrong");
   byte_order_a: assert property (sub_valid_o |->
      sub_rec_o.little_e == sub_rec_o.flags[0]) else $error("order wrong");
   unused_zero_a: assert property (sub_valid_o &&
      sub_rec_o.kind == 8'h06 |-> sub_rec_o.flags[7:2] == 6'h00)
      else $error("unused flags kept");
   reply_owed_a: assert property (sub_valid_o |->
      sub_rec_o.reply_req == (sub_rec_o.kind == 8'h06 && !sub_rec_o.flags[1]))
      else $error("reply flag wrong");
   nokey_flags_a: assert property (sub_valid_o |->
      {sub_rec_o.data_present, sub_rec_o.inline_qos} ==
      (sub_rec_o.kind == 8'h03 ? sub_rec_o.flags[2:1] : 2'h0))
      else $error("data flags wrong");
   zero_final_a: assert property (sub_valid_o &&
      sub_rec_o.octets == 16'h0000 && sub_rec_o.kind != 8'h01 &&
      sub_rec_o.kind != 8'h09 |-> sub_rec_o.final_sub)
      else $error("zero length not final");
   done_pulse_a: assert property (msg_done_o |=> !msg_done_o)
      else $error("done pulse too long");
endmodule
bind pss_parser pss_parser_sva #(.LEN_W(LEN_W)) u_pss_parser_sva (
   .clk_sys_i(clk_sys_i), .reset_i(reset_i), .sub_valid_o(sub_valid_o),
   .sub_ready_i(sub_ready_i), .sub_rec_o(sub_rec_o),
   .msg_done_o(msg_done_o));

// ==== pss_peer.sv ====
`timescale 1ns/1ps
module pss_peer (
   // Clock and pacing
   input  wire logic       clk_sys_i,
   input  wire logic [3:0] gap_i,
   // Byte stream to the parser
   input  wire logic       byte_ready_i,
   output logic            byte_valid_o,
   output logic [7:0]      byte_o,
   output logic            msg_start_o,
   output logic [31:0]     msg_len_o
);
   // Idle lines at time zero
   initial
   begin
      byte_valid_o = 1'b0;
      byte_o = 8'hA5;
      msg_start_o = 1'b0;
      msg_len_o = 32'h0;
   end
   // One message, octets in order, each held until accepted
   task automatic send(input logic [7:0] m [$]);
      for (int i = 0; i < m.size(); i++)
      begin
         @(negedge clk_sys_i);
         byte_valid_o = 1'b1;
         byte_o = m[i];
         msg_start_o = (i == 0);
         msg_len_o = m.size();
         while (byte_ready_i !== 1'b1)
            @(negedge clk_sys_i);
         @(posedge clk_sys_i);
         // Slow sender: released data is inverted on each idle cycle, so every second one shows the old octet again
         repeat (gap_i)
         begin
            @(negedge clk_sys_i);
            byte_valid_o = 1'b0;
            byte_o = ~byte_o;
         end
      end
      @(negedge clk_sys_i);
      byte_valid_o = 1'b0;
      byte_o = ~byte_o;
      msg_start_o = 1'b0;
   endtask
endmodule

// ==== pss_pkg.sv ====
package pss_pkg;
   // Walk states
   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_HDR   = 3'b001,
      S_BODY  = 3'b010,
      S_EMIT  = 3'b011,
      S_DRAIN = 3'b100
   } pss_state_e;
   // One decoded submessage
   typedef struct packed {
      logic [15:0] vendor_id;
      logic [7:0]  kind;
      logic [7:0]  flags;
      logic [15:0] octets;
      logic        little_e;
      logic        proto_kind;
      logic        vendor_kind;
      logic        known_kind;
      logic        final_sub;
      logic        reply_req;
      logic        inline_qos;
      logic        data_present;
      logic        loc_valid;
      logic [31:0] loc_addr;
      logic [31:0] loc_port;
   } pss_rec_s;
endpackage

// ==== pss_rec_if.sv ====
`timescale 1ns/1ps
interface pss_rec_if;
   logic              valid;
   logic              ready;
   pss_pkg::pss_rec_s data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
   // Parser pins
   logic              clk_sys_i = 1'b0;
   logic              reset_i = 1'b1;
   logic              byte_valid_i, byte_ready_o, msg_start_i;
   logic [31:0]       msg_len_i;
   logic [7:0]        byte_i;
   logic              sub_valid_o, malformed_o, align_err_o, msg_done_o;
   logic              sub_ready_i = 1'b1;
   pss_pkg::pss_rec_s sub_rec_o;
   logic [15:0]       vendor_id_i = 16'h5A3C; // Arbitrary id
   logic [3:0]        gap = 4'h0;
   // Bookkeeping
   int                miscompares = 0;
   int                num_checks = 0;
   int                dones = 0;
   pss_pkg::pss_rec_s got [$];
   pss_pkg::pss_rec_s last;
   logic [7:0]        m [$];
   logic [7:0]        kinds [$] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05,
      8'h06, 8'h07, 8'h08, 8'h09, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10,
      8'h11, 8'h12, 8'h13, 8'h14, 8'h7F, 8'h80, 8'hFF};

   always #50 clk_sys_i = ~clk_sys_i;

   pss_parser u_pss_parser (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .msg_start_i(msg_start_i), .msg_len_i(msg_len_i),
      .vendor_id_i(vendor_id_i), .byte_valid_i(byte_valid_i),
      .byte_i(byte_i), .byte_ready_o(byte_ready_o),
      .sub_valid_o(sub_valid_o), .sub_ready_i(sub_ready_i),
      .sub_rec_o(sub_rec_o), .malformed_o(malformed_o),
      .align_err_o(align_err_o), .msg_done_o(msg_done_o));
   pss_peer u_pss_peer (.clk_sys_i(clk_sys_i), .gap_i(gap),
      .byte_ready_i(byte_ready_o), .byte_valid_o(byte_valid_i),
      .byte_o(byte_i), .msg_start_o(msg_start_i), .msg_len_o(msg_len_i));

   // Collect records as they are taken, count end-of-walk pulses
   always @(posedge clk_sys_i)
   begin
      if (sub_valid_o && sub_ready_i)
         got.push_back(sub_rec_o);
      if (msg_done_o === 1'b1)
         dones++;
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] seen);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Send the message and wait for the end of its walk
   task automatic run();
      int n;
      int d0;
      n = 0;
      d0 = dones;
      u_pss_peer.send(m);
      while (dones == d0 && n < 60)
      begin
         @(negedge clk_sys_i);
         n++;
      end
      // Last record reaches the consumer in the same cycle as the pulse
      repeat (2) @(negedge clk_sys_i);
      chk("done", 1, dones == d0 + 1);
      m.delete();
   endtask

   // Next record against the expected header decode
   task automatic rec_chk(input logic [7:0] k, input logic [7:0] f,
                          input logic [15:0] len, input logic fin,
                          input logic lv);
      chk("records", 1, got.size() != 0);
      if (got.size() != 0)
         last = got.pop_front();
      chk("kind", k, last.kind);
      chk("flags", f, last.flags);
      chk("octets", len, last.octets);
      chk("final", fin, last.final_sub);
      chk("vid", vendor_id_i, last.vendor_id);
      chk("proto", k <= 8'h7F, last.proto_kind);
      chk("vendor", k[7], last.vendor_kind);
      chk("known", k inside {[8'h01:8'h03], [8'h06:8'h09],
          [8'h0C:8'h13]}, last.known_kind);
      chk("little", f[0], last.little_e);
      chk("reply", k == 8'h06 && !f[1], last.reply_req);
      chk("qos", k == 8'h03 && f[1], last.inline_qos);
      chk("data", k == 8'h03 && f[2], last.data_present);
      chk("loc", lv, last.loc_valid);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (10) @(negedge clk_sys_i);
      reset_i = 1'b0;
      // Mixed walk, slow sender, both byte orders
      gap = 4'h2;
      m = '{8'h06, 8'hF8, 8'h00, 8'h04, 8'hC0, 8'hC1, 8'hC2, 8'hC3,
            8'h03, 8'h07, 8'h04, 8'h00, 8'hD0, 8'hD1, 8'hD2, 8'hD3,
            8'h01, 8'h00, 8'h00, 8'h00, 8'h06, 8'h03, 8'h04, 8'h00,
            8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'h0D, 8'h00, 8'h00, 8'h08,
            8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h00, 8'h00, 8'h1C, 8'hE9};
      run();
      gap = 4'h0;
      rec_chk(8'h06, 8'h00, 16'h0004, 0, 0);
      rec_chk(8'h03, 8'h07, 16'h0004, 0, 0);
      rec_chk(8'h01, 8'h00, 16'h0000, 0, 0);
      rec_chk(8'h06, 8'h03, 16'h0004, 0, 0);
      rec_chk(8'h0D, 8'h00, 16'h0008, 1, 1);
      chk("addr", 32'h0A0B0C0D, last.loc_addr);
      chk("port", 32'h00001CE9, last.loc_port);
      chk("align", 0, align_err_o);
      // Every kind class, zero length, alone in its message
      foreach (kinds[i])
      begin
         m = '{kinds[i], 8'h02, 8'h00, 8'h00};
         vendor_id_i = {8'h5A, kinds[i]};
         run();
         rec_chk(kinds[i], (kinds[i] == 8'h08) ? 8'h00 : 8'h02,
                 16'h0000, 1, 0);
      end
      // Zero length data runs to the end of the message
      m = '{8'h02, 8'h01, 8'h00, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44};
      run();
      rec_chk(8'h02, 8'h01, 16'h0000, 1, 0);
      chk("extra", 0, got.size());
      // Length past the message end
      m = '{8'h06, 8'h00, 8'h00, 8'h10, 8'h01, 8'h02, 8'h03, 8'h04};
      run();
      chk("malformed", 1, malformed_o);
      chk("bad recs", 0, got.size());
      // Next header on a two octet offset
      m = '{8'h03, 8'h00, 8'h00, 8'h02, 8'hAA, 8'hBB,
            8'h01, 8'h00, 8'h00, 8'h00};
      run();
      chk("malformed", 0, malformed_o);
      chk("align", 1, align_err_o);
      rec_chk(8'h03, 8'h00, 16'h0002, 0, 0);
      rec_chk(8'h01, 8'h00, 16'h0000, 1, 0);
      // Consumer stalls: buffer fills, byte stream holds
      sub_ready_i = 1'b0;
      m = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
            8'h01, 8'h00, 8'h00, 8'h00, 8'h09, 8'h01, 8'h00, 8'h00};
      fork
         run();
         begin
            repeat (30) @(negedge clk_sys_i);
            chk("stall", 0, byte_ready_o);
            sub_ready_i = 1'b1;
         end
      join
      for (int i = 0; i < 3; i++)
         rec_chk(8'h01, 8'h00, 16'h0000, 0, 0);
      rec_chk(8'h09, 8'h01, 16'h0000, 1, 0);
      wrap_up();
   end

   // Watchdog, far beyond the few hundred cycles the tests take
   initial
   begin
      #(3000 * 100);
      miscompares++;
      wrap_up();
   end
endmodule
